// ### hw/rvt_ring_validator.sv
// Behaviour
// - With ring_check_enable low validation is off; when high it runs in normal and low-power mode alike.
// - Every tip/ring event with ring_check_enable high reloads the interval timer with the slow-limit count, which then counts down and holds at zero.
// - A second or later event after the timer has expired marks the ring invalid as too slow.
// - Events closer than slow-limit minus fast_limit_count steps of 2.0 ms are rejected as too fast.
// - The slow-limit count sets the lowest accepted ring frequency.
// - After validation a valid_report_delay of 0 to 1792 ms passes before the valid ring is shown.
// - The ring is over once ring_end_timeout times 128 ms pass after the latest crossing; code zero counts as one step.
// - A ring is valid only after its frequency stays in tolerance for the confirm_time_select time.
`timescale 1ns/100ps
module rvt_ring_validator #(
  parameter int TICK_CYCLES = rvt_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line side
  input wire logic ring_event,
  input wire logic low_power,
  // results
  output logic ring_valid,
  output logic irq
);
  // ==================================================
  // registers
  logic en_r;
  logic [5:0] slow_r;
  logic [5:0] fast_r;
  logic [2:0] dly_r;
  logic [3:0] to_r;
  logic [2:0] conf_r;
  logic [rvt_pkg::ST_WIDTH-1:0] status_r;
  logic [rvt_pkg::ST_WIDTH-1:0] mask_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata_nxt;
  logic [rvt_pkg::ST_WIDTH-1:0] ev_set;
  logic setup;
  logic wr;
  logic mapped;

  rvt_pkg::rvt_state_t state_r;
  logic [5:0] timer_count;
  logic timer_expired;
  logic timer_load;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign mapped = (paddr == rvt_pkg::ADDR_CTRL) || (paddr == rvt_pkg::ADDR_AUX) ||
                  (paddr == rvt_pkg::ADDR_STATUS) || (paddr == rvt_pkg::ADDR_MASK) ||
                  (paddr == rvt_pkg::ADDR_STATE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;

  // reserved bit 6 is not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= rvt_pkg::CTRL_RESET[rvt_pkg::CTRL_EN_BIT];
      slow_r <= rvt_pkg::CTRL_RESET[rvt_pkg::CTRL_SLOW_LSB +: 6];
    end else if (wr && paddr == rvt_pkg::ADDR_CTRL) begin
      en_r <= pwdata[rvt_pkg::CTRL_EN_BIT];
      slow_r <= pwdata[rvt_pkg::CTRL_SLOW_LSB +: 6];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_r <= rvt_pkg::FAST_RESET;
      dly_r <= rvt_pkg::DLY_RESET;
      to_r <= rvt_pkg::TO_RESET;
      conf_r <= rvt_pkg::CONF_RESET;
    end else if (wr && paddr == rvt_pkg::ADDR_AUX) begin
      fast_r <= pwdata[rvt_pkg::AUX_FAST_LSB +: 6];
      dly_r <= pwdata[rvt_pkg::AUX_DLY_LSB +: 3];
      to_r <= pwdata[rvt_pkg::AUX_TO_LSB +: 4];
      conf_r <= pwdata[rvt_pkg::AUX_CONF_LSB +: 3];
    end
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else if (wr && paddr == rvt_pkg::ADDR_STATUS) begin
      status_r <= (status_r & ~pwdata[rvt_pkg::ST_WIDTH-1:0]) | ev_set;
    end else begin
      status_r <= status_r | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= '0;
    end else if (wr && paddr == rvt_pkg::ADDR_MASK) begin
      mask_r <= pwdata[rvt_pkg::ST_WIDTH-1:0];
    end
  end

  assign irq = |(status_r & mask_r);

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      rvt_pkg::ADDR_CTRL: begin
        rdata_nxt[rvt_pkg::CTRL_EN_BIT] = en_r;
        rdata_nxt[rvt_pkg::CTRL_SLOW_LSB +: 6] = slow_r;
      end
      rvt_pkg::ADDR_AUX: begin
        rdata_nxt[rvt_pkg::AUX_FAST_LSB +: 6] = fast_r;
        rdata_nxt[rvt_pkg::AUX_DLY_LSB +: 3] = dly_r;
        rdata_nxt[rvt_pkg::AUX_TO_LSB +: 4] = to_r;
        rdata_nxt[rvt_pkg::AUX_CONF_LSB +: 3] = conf_r;
      end
      rvt_pkg::ADDR_STATUS: rdata_nxt[rvt_pkg::ST_WIDTH-1:0] = status_r;
      rvt_pkg::ADDR_MASK: rdata_nxt[rvt_pkg::ST_WIDTH-1:0] = mask_r;
      rvt_pkg::ADDR_STATE: begin
        rdata_nxt[1:0] = state_r;
        rdata_nxt[2] = ring_valid;
        rdata_nxt[3] = timer_expired;
        rdata_nxt[4] = low_power;
        rdata_nxt[13:8] = timer_count;
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle, so access is zero-wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_r <= rdata_nxt;
    end
  end

  // ==================================================
  // 2 ms tick divider
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  logic [DIV_W-1:0] div_r;
  logic tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else if (div_r == DIV_W'(TICK_CYCLES - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign tick = (div_r == DIV_W'(TICK_CYCLES - 1));

  // ==================================================
  // qualification
  logic [rvt_pkg::CNT_W-1:0] phase_r;
  logic [rvt_pkg::CNT_W-1:0] since_r;
  logic [rvt_pkg::CNT_W-1:0] to_ticks;
  logic [rvt_pkg::CNT_W-1:0] dly_ticks;
  logic too_slow;
  logic too_fast;
  logic bad_event;
  logic ring_over;
  logic active;

  rvt_interval_timer #(
    .WIDTH(6)
  ) rvt_interval_timer_inst (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .load(timer_load),
    .load_value(slow_r),
    .count(timer_count),
    .expired(timer_expired)
  );

  assign active = en_r && (state_r != rvt_pkg::RVT_IDLE);
  assign timer_load = en_r && ring_event;
  assign too_slow = timer_expired;
  assign too_fast = timer_count > fast_r;
  assign bad_event = active && ring_event && (too_slow || too_fast);
  // zero code treated as one step
  assign to_ticks = rvt_pkg::CNT_W'((to_r == 4'h0 ? 4'h1 : to_r) * rvt_pkg::TIMEOUT_STEP_TICKS);
  assign dly_ticks = rvt_pkg::CNT_W'(dly_r * rvt_pkg::DELAY_STEP_TICKS);
  assign ring_over = active && !ring_event && tick && (since_r + 1'b1 >= to_ticks);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= '0;
    end else if (ring_event || !active) begin
      since_r <= '0;
    end else if (tick && since_r != {rvt_pkg::CNT_W{1'b1}}) begin
      since_r <= since_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rvt_pkg::RVT_IDLE;
      phase_r <= '0;
    end else if (!en_r) begin
      state_r <= rvt_pkg::RVT_IDLE;
      phase_r <= '0;
    end else if (bad_event) begin
      state_r <= rvt_pkg::RVT_QUAL;
      phase_r <= '0;
    end else if (ring_over) begin
      state_r <= rvt_pkg::RVT_IDLE;
      phase_r <= '0;
    end else begin
      case (state_r)
        rvt_pkg::RVT_IDLE: begin
          if (ring_event) begin
            state_r <= rvt_pkg::RVT_QUAL;
            phase_r <= '0;
          end
        end
        rvt_pkg::RVT_QUAL: begin
          if (tick) begin
            if (phase_r + 1'b1 >= rvt_pkg::confirm_ticks(conf_r)) begin
              state_r <= rvt_pkg::RVT_DELAY;
              phase_r <= '0;
            end else begin
              phase_r <= phase_r + 1'b1;
            end
          end
        end
        rvt_pkg::RVT_DELAY: begin
          if (dly_ticks == '0 || (tick && phase_r + 1'b1 >= dly_ticks)) begin
            state_r <= rvt_pkg::RVT_VALID;
            phase_r <= '0;
          end else if (tick) begin
            phase_r <= phase_r + 1'b1;
          end
        end
        rvt_pkg::RVT_VALID: phase_r <= '0;
        default: begin
          state_r <= rvt_pkg::RVT_IDLE;
          phase_r <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ring_valid <= 1'b0;
    end else begin
      ring_valid <= en_r && !bad_event && !ring_over &&
                    (state_r == rvt_pkg::RVT_VALID ||
                     (state_r == rvt_pkg::RVT_DELAY &&
                      (dly_ticks == '0 || (tick && phase_r + 1'b1 >= dly_ticks))));
    end
  end

  always_comb begin
    ev_set = '0;
    ev_set[rvt_pkg::ST_VALID_BIT] = ring_valid == 1'b0 && en_r && !bad_event && !ring_over &&
                                    state_r == rvt_pkg::RVT_DELAY &&
                                    (dly_ticks == '0 || (tick && phase_r + 1'b1 >= dly_ticks));
    ev_set[rvt_pkg::ST_INVALID_BIT] = en_r && bad_event;
    ev_set[rvt_pkg::ST_END_BIT] = en_r && ring_over && state_r == rvt_pkg::RVT_VALID;
  end
endmodule

// ### hw/rvt_pkg.sv
package rvt_pkg;
  // ==================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_AUX = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_MASK = 8'h24;
  localparam logic [7:0] ADDR_STATE = 8'h28;

  // ==================================================
  // ring_check_control fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_SLOW_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h19;

  // ==================================================
  // auxiliary control fields
  localparam int AUX_FAST_LSB = 0;
  localparam int AUX_DLY_LSB = 6;
  localparam int AUX_TO_LSB = 9;
  localparam int AUX_CONF_LSB = 13;
  localparam logic [5:0] FAST_RESET = 6'h0A;
  localparam logic [2:0] DLY_RESET = 3'h0;
  localparam logic [3:0] TO_RESET = 4'h5;
  localparam logic [2:0] CONF_RESET = 3'h5;

  // ==================================================
  // status / mask bits
  localparam int ST_VALID_BIT = 0;
  localparam int ST_INVALID_BIT = 1;
  localparam int ST_END_BIT = 2;
  localparam int ST_WIDTH = 3;

  // ==================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STEP_NS = 2000000;
  localparam int TICK_CYCLES = STEP_NS / CLK_PERIOD_NS;
  localparam int DELAY_STEP_MS = 256;
  localparam int TIMEOUT_STEP_MS = 128;
  localparam int STEP_MS = 2;
  localparam int DELAY_STEP_TICKS = DELAY_STEP_MS / STEP_MS;
  localparam int TIMEOUT_STEP_TICKS = TIMEOUT_STEP_MS / STEP_MS;
  localparam int CNT_W = 10;

  // confirmation times in 2 ms steps (100,150,200,256,384,512,640,1024 ms)
  function automatic logic [CNT_W-1:0] confirm_ticks(input logic [2:0] sel);
    case (sel)
      3'h0: confirm_ticks = 10'h032;
      3'h1: confirm_ticks = 10'h04B;
      3'h2: confirm_ticks = 10'h064;
      3'h3: confirm_ticks = 10'h080;
      3'h4: confirm_ticks = 10'h0C0;
      3'h5: confirm_ticks = 10'h100;
      3'h6: confirm_ticks = 10'h140;
      default: confirm_ticks = 10'h200;
    endcase
  endfunction

  typedef enum logic [1:0] {RVT_IDLE, RVT_QUAL, RVT_DELAY, RVT_VALID} rvt_state_t;
endpackage

// ### hw/rvt_interval_timer.sv
`timescale 1ns/100ps
module rvt_interval_timer #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  // state
  output logic [WIDTH-1:0] count,
  output logic expired
);
  logic [WIDTH-1:0] count_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= load_value;
    end else if (tick && count_r != '0) begin
      count_r <= count_r - 1'b1;
    end
  end

  assign count = count_r;
  assign expired = (count_r == '0);
endmodule

// ### bench/rvt_line_model.sv
`timescale 1ns/100ps
// ==========
// line-side event source
module rvt_line_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pacing
  input wire logic run,
  input wire logic [15:0] gap,
  // line side
  output logic ring_event
);
  logic [15:0] cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      ring_event <= 1'b0;
    end else begin
      ring_event <= run && cnt_r == 16'h0000;
      cnt_r <= (!run || cnt_r == 16'h0000) ? gap - 16'h0001 : cnt_r - 16'h0001;
    end
  end
endmodule

// ### bench/rvt_ring_validator_asserts.sv
`timescale 1ns/100ps
module rvt_ring_validator_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // results
  input wire logic ring_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // helpers
  logic en_r;
  logic acc;
  logic mapped;
  assign acc = psel && penable;
  assign mapped = paddr inside {rvt_pkg::ADDR_CTRL, rvt_pkg::ADDR_AUX, rvt_pkg::ADDR_STATUS,
    rvt_pkg::ADDR_MASK, rvt_pkg::ADDR_STATE};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 1'b0;
    end else if (acc && pwrite && paddr == rvt_pkg::ADDR_CTRL) begin
      en_r <= pwdata[rvt_pkg::CTRL_EN_BIT];
    end
  end
  sequence s_rd_ctrl;
    acc && !pwrite && paddr == rvt_pkg::ADDR_CTRL;
  endsequence
  sequence s_off;
    !en_r [*3];
  endsequence
  // ==========
  // properties
  a_ready_high: assert property (acc |-> pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no pslverr");
  a_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("bad pslverr");
  a_rd_unmapped: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0) else $error("rdata");
  a_ctrl_bit6: assert property (s_rd_ctrl |-> prdata[31:8] == 24'h0 && !prdata[6])
    else $error("ctrl bits");
  a_ctrl_enable: assert property (s_rd_ctrl |-> prdata[7] == en_r) else $error("enable");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("prdata");
  a_off_invalid: assert property (s_off |-> !ring_valid) else $error("valid off");
  a_valid_enabled: assert property ($rose(ring_valid) |-> en_r) else $error("valid rise");
endmodule
bind rvt_ring_validator rvt_ring_validator_asserts rvt_ring_validator_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ring_valid(ring_valid));

// ### bench/test_ring_validation_timing.sv
`timescale 1ns/100ps
module test_ring_validation_timing;
  // ==========
  // signals
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ring_event;
  logic low_power;
  logic ring_valid;
  logic irq;
  logic run;
  logic [15:0] gap;
  logic [31:0] q;
  logic err;
  int fails;
  int check_count;
  // short tick keeps ring timing inside a few thousand cycles
  rvt_ring_validator #(.TICK_CYCLES(4)) rvt_ring_validator_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ring_event(ring_event), .low_power(low_power), .ring_valid(ring_valid), .irq(irq));
  rvt_line_model rvt_line_model_inst (
    .pclk(pclk), .presetn(presetn), .run(run), .gap(gap), .ring_event(ring_event));
  // ==========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a stalled access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_rv(input logic v, input int lim);
    int n;
    n = 0;
    while (ring_valid !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic burst(input logic [15:0] g, input int n);
    gap <= g;
    run <= 1'b1;
    repeat (n) @(posedge pclk);
    run <= 1'b0;
  endtask
  task automatic t_reset;
    apb(1'b0, rvt_pkg::ADDR_CTRL, 32'h0);
    chk(q, 32'h19);
    apb(1'b0, rvt_pkg::ADDR_AUX, 32'h0);
    chk(q, 32'hAA0A);
    apb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk(32'(err), 32'h1);
    $display("test reset done");
  endtask
  task automatic t_off;
    burst(16'd80, 400);
    apb(1'b0, rvt_pkg::ADDR_STATE, 32'h0);
    chk(q & 32'h3, 32'h0);
    apb(1'b0, rvt_pkg::ADDR_STATUS, 32'h0);
    chk(q, 32'h0);
    $display("test off done");
  endtask
  task automatic t_good;
    // one delay step, shortest timeout, shortest confirm time
    apb(1'b1, rvt_pkg::ADDR_AUX, 32'h024A);
    apb(1'b1, rvt_pkg::ADDR_MASK, 32'h7);
    apb(1'b1, rvt_pkg::ADDR_CTRL, 32'h99);
    low_power <= 1'b1;
    gap <= 16'd80;
    run <= 1'b1;
    repeat (100) @(posedge pclk);
    chk(32'(ring_valid), 32'h0);
    repeat (300) @(posedge pclk);
    apb(1'b0, rvt_pkg::ADDR_STATE, 32'h0);
    // confirmed, still in report delay, low-power reported
    chk(q & 32'h17, 32'h12);
    wait_rv(1'b1, 800);
    chk(32'(ring_valid), 32'h1);
    apb(1'b0, rvt_pkg::ADDR_STATUS, 32'h0);
    chk(q, 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b1, rvt_pkg::ADDR_STATUS, 32'h1);
    chk(32'(irq), 32'h0);
    run <= 1'b0;
    repeat (150) @(posedge pclk);
    chk(32'(ring_valid), 32'h1);
    wait_rv(1'b0, 300);
    chk(32'(ring_valid), 32'h0);
    apb(1'b0, rvt_pkg::ADDR_STATUS, 32'h0);
    chk(q, 32'h4);
    apb(1'b1, rvt_pkg::ADDR_STATUS, 32'h4);
    low_power <= 1'b0;
    $display("test good done");
  endtask
  task automatic t_slow;
    apb(1'b1, rvt_pkg::ADDR_MASK, 32'h0);
    burst(16'd120, 400);
    repeat (110) @(posedge pclk);
    apb(1'b0, rvt_pkg::ADDR_STATE, 32'h0);
    chk(q & 32'h3F08, 32'h8);
    apb(1'b0, rvt_pkg::ADDR_STATUS, 32'h0);
    chk(q, 32'h2);
    chk(32'(irq), 32'h0);
    apb(1'b1, rvt_pkg::ADDR_MASK, 32'h2);
    chk(32'(irq), 32'h1);
    apb(1'b1, rvt_pkg::ADDR_STATUS, 32'h2);
    chk(32'(irq), 32'h0);
    $display("test slow done");
  endtask
  task automatic t_fast;
    burst(16'd40, 300);
    apb(1'b0, rvt_pkg::ADDR_STATUS, 32'h0);
    chk(q, 32'h2);
    $display("test fast done");
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #(30000 * 25);
    fails++;
    give_verdict;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    low_power = 1'b0;
    run = 1'b0;
    gap = 16'd80;
    fails = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_off;
    t_good;
    t_slow;
    t_fast;
    give_verdict;
  end
endmodule
